// *** apdc_defines.svh ***
/*
 * Constants of the automatic power-down controller: register offsets,
 * field positions, masks, reset values and the idle period count.
 * Assumes it is included once per compilation unit by bare name.
 */
`ifndef APDC_DEFINES_SVH
`define APDC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define APDC_PM0_OFS 8'h00
`define APDC_PM2_OFS 8'h02
`define APDC_STAT_OFS 8'h04

// ----------------------------------------------------------------------
// Control register 0 fields
// ----------------------------------------------------------------------
`define APDC_PM0_APD_EN 1
`define APDC_PM0_TURBO_OFF 3
`define APDC_PM0_ARR_CLK_OFF 4
`define APDC_PM0_MCELL_CLK_OFF 5
`define APDC_PM0_MASK 8'h3A

// ----------------------------------------------------------------------
// Control register 2 fields
// ----------------------------------------------------------------------
`define APDC_PM2_WR_OFF 2
`define APDC_PM2_RD_OFF 3
`define APDC_PM2_PROGRAM_STORE_ENABLE_OFF 4
`define APDC_PM2_ALE_OFF 5
`define APDC_PM2_MASK 8'h3C

// ----------------------------------------------------------------------
// Status fields, reset values, counts
// ----------------------------------------------------------------------
`define APDC_STAT_PDN 0
`define APDC_STAT_CNTG 1
`define APDC_STAT_CNT_LSB 4
`define APDC_REG_RST 8'h00
`define APDC_CNT_RST 4'h0
`define APDC_IDLE_PERIODS 4'hF

`endif

// *** apdc_mcu_model.sv ***
/*
 * MCU-side pin model: address strobe, pin clock, chip-select, strobes.
 * Assumes the bench clock; the pin clock runs at an eighth of it.
 */
`timescale 1ns/100ps
module apdc_mcu_model (
    // Bench controls
    input wire logic clk_i,
    input wire logic ale_run_i,
    input wire logic cs_n_i,
    // Pins toward the device
    output logic ale_o = 1'b0,
    output logic pin_clk_o = 1'b0,
    output logic cs_n_o = 1'b1,
    output logic wr_n_o = 1'b1,
    output logic rd_n_o = 1'b1,
    output logic program_store_enable_n_o = 1'b1
);
    logic [2:0] div_q = 3'h0;

    // Strobe parks low when stopped; slow pin clock keeps the sync honest
    always @(posedge clk_i) begin
        div_q <= div_q + 3'h1;
        pin_clk_o <= div_q[2];
        ale_o <= ale_run_i & div_q[1];
        program_store_enable_n_o <= ~(ale_run_i & div_q[0]);
        rd_n_o <= ~(ale_run_i & div_q[2]);
        wr_n_o <= 1'b1;
        cs_n_o <= cs_n_i;
    end
endmodule : apdc_mcu_model

// *** apdc_pkg.sv ***
/*
 * Types shared by the automatic power-down controller.
 * Assumes apdc_defines.svh supplies the numeric constants.
 */
package apdc_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Gray coded along off -> watch -> down
    typedef enum logic [1:0] {
        APDC_OFF = 2'b00,
        APDC_WATCH = 2'b01,
        APDC_DOWN = 2'b11
    } apdc_state_e;

    typedef logic [7:0] apdc_reg_t;

    // MCU control strobes as seen by the PLD AND array
    typedef struct packed {
        logic wr_n;
        logic rd_n;
        logic program_store_enable_n;
        logic ale;
    } apdc_pld_ctrl_s;

    // Port pin behaviour requests during power-down
    typedef struct packed {
        logic hold_mcu_io;
        logic hold_pld_out;
        logic addr_out_invalid;
        logic periph_tristate;
    } apdc_pin_ctrl_s;

endpackage : apdc_pkg

// *** apdc_properties.sv ***
/*
 * Checker for apdc_top: power-down entry, exit and blocking.
 * Assumes a bind to apdc_top and a pin clock well below sys_clk_i/4.
 */
`timescale 1ns/100ps
module apdc_properties import apdc_pkg::*; (
    // Clock and resets
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic por_i,
    // Watched ports
    input wire logic reg_wr_i,
    input wire logic ale_pin_i,
    input wire logic pld_input_clock_i,
    input wire logic chip_select_n_i,
    input wire logic power_down_flag_o,
    input wire logic mcu_bus_block_o,
    input wire logic mem_enable_o,
    input wire logic pld_turbo_off_o,
    input wire apdc_pin_ctrl_s pin_ctrl_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (por_i);

    // Pin-clock edges since strobe activity; cleared by cs low or reset
    logic [7:0] edges_q;
    logic clk_prev_q;
    logic ale_prev_q;
    always_ff @(posedge sys_clk_i) begin
        clk_prev_q <= pld_input_clock_i;
        ale_prev_q <= ale_pin_i;
        if (por_i || srst_i || !chip_select_n_i || ale_pin_i != ale_prev_q) begin
            edges_q <= 8'h00;
        end else if (pld_input_clock_i && !clk_prev_q && edges_q != 8'hFF) begin
            edges_q <= edges_q + 8'h01;
        end
    end

    sequence s_cs_held_low;
        !chip_select_n_i [*5];
    endsequence
    sequence s_wake_in_down;
        power_down_flag_o ##0 $changed(ale_pin_i);
    endsequence

    AST_BLOCK_FOLLOWS: assert property (mcu_bus_block_o == power_down_flag_o)
        else $error("bus block differs from power-down flag");
    AST_MEM_DESELECT: assert property (power_down_flag_o |-> !mem_enable_o)
        else $error("memories selected in power-down");
    AST_PIN_REQ: assert property (pin_ctrl_o == {4{power_down_flag_o}})
        else $error("pin requests differ from power-down flag");
    AST_CS_EXIT: assert property (s_cs_held_low |-> !power_down_flag_o)
        else $error("power-down held with chip-select low");
    AST_RST_EXIT: assert property (srst_i |=> ##1 !power_down_flag_o)
        else $error("power-down held after warm reset");
    AST_ALE_EXIT: assert property (
        s_wake_in_down |-> ##[1:6] !power_down_flag_o)
        else $error("power-down held after strobe activity");
    AST_ENTRY_COUNT: assert property (
        $rose(power_down_flag_o) |-> edges_q inside {[14:16]})
        else $error("power-down entered after wrong idle count");
    AST_REG_HOLD: assert property (
        !$past(reg_wr_i) && !$past(reg_wr_i, 2) |-> $stable(pld_turbo_off_o))
        else $error("turbo control changed without a write");
endmodule : apdc_properties

bind apdc_top apdc_properties u_apdc_properties (
    .sys_clk_i, .srst_i, .por_i, .reg_wr_i, .ale_pin_i, .pld_input_clock_i,
    .chip_select_n_i, .power_down_flag_o, .mcu_bus_block_o, .mem_enable_o,
    .pld_turbo_off_o, .pin_ctrl_o
);

// *** apdc_top.sv ***
/*
 * Automatic power-down controller: idle watch on the address strobe,
 * power-down flag, two power management registers and PLD gating.
 * Assumes the MCU reaches the registers over a plain strobe port on
 * sys_clk_i, and that all pin inputs are asynchronous to that clock.
 */
//
// Behaviour
// [R1] Fifteen idle input-clock periods raise power-down
// [R2] Control 0 bit 1 enables auto power-down
// [R3] Strobe pulsing again leaves power-down
// [R4] Chip-select low or reset leaves power-down
// [R5] Power-down blocks bus, deselects memories
// [R6] PLD clock gating never stops counter
// [R7] Power-down holds, undefines, tri-states pins
// [R8] Control 0 bit 3 turns turbo off
// [R9] Control 0 bit 4 gates array clock
// [R10] Control 0 bit 5 gates macrocell clock
// [R11] Software writes zero to unused bits
// [R12] Chip-select low enables memories and I/O; the code gates only mem_enable_o, and I/O stays live
// [R13] Control 2 bits disconnect MCU strobes
// [R14] Bits 2-5 gate write, read, PROGRAM_STORE_ENABLE, strobe
// [R15] Count only when enabled and strobe static
// [R16] Registers clear at power-up, keep warm reset
// [R17] Strobe edge clears counter and flag
`timescale 1ns/100ps
`include "apdc_defines.svh"

module apdc_top
    import apdc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 4
) (
    // Clock and resets
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic por_i,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // MCU and port pins
    input wire logic ale_pin_i,
    input wire logic pld_input_clock_i,
    input wire logic chip_select_n_i,
    input wire logic mcu_wr_n_i,
    input wire logic mcu_rd_n_i,
    input wire logic program_store_enable_n_i,
    // Power-down status and blocking
    output logic power_down_flag_o,
    output logic mcu_bus_block_o,
    output logic mem_enable_o,
    // PLD power controls
    output logic pld_turbo_off_o,
    output logic pld_array_clk_o,
    output logic pld_mcell_clk_o,
    output apdc_pld_ctrl_s pld_ctrl_o,
    // Port pin controls
    output apdc_pin_ctrl_s pin_ctrl_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Address match, sized to the port width
    function automatic logic hit(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0] ofs
    );
        hit = (addr == ADDR_W'(ofs));
    endfunction : hit

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int NSYNC = 6;

    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic ale_prev_q;
    logic clk_prev_q;

    assign pins_raw = {program_store_enable_n_i, mcu_rd_n_i, mcu_wr_n_i,
                       chip_select_n_i, pld_input_clock_i, ale_pin_i};

    // First stage is read only by the second stage
    always_ff @(posedge sys_clk_i) begin
        sync1_q <= pins_raw;
        sync2_q <= sync1_q;
    end

    wire ale_s = sync2_q[0];
    wire inclk_s = sync2_q[1];
    wire cs_n_s = sync2_q[2];
    wire wr_n_s = sync2_q[3];
    wire rd_n_s = sync2_q[4];
    wire program_store_enable_n_s = sync2_q[5];

    // Edge history on the synchronised copies
    always_ff @(posedge sys_clk_i) begin
        if (por_i) begin
            ale_prev_q <= 1'b0;
            clk_prev_q <= 1'b0;
        end else begin
            ale_prev_q <= ale_s;
            clk_prev_q <= inclk_s;
        end
    end

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    apdc_reg_t pm0_q;
    apdc_reg_t pm0_d;
    apdc_reg_t pm2_q;
    apdc_reg_t pm2_d;

    wire sel_pm0 = hit(reg_addr_i, `APDC_PM0_OFS);
    wire sel_pm2 = hit(reg_addr_i, `APDC_PM2_OFS);
    wire sel_stat = hit(reg_addr_i, `APDC_STAT_OFS);
    wire wr_pm0 = reg_wr_i & sel_pm0;
    wire wr_pm2 = reg_wr_i & sel_pm2;

    // Unused bits are not stored, so they always read back as zero
    assign pm0_d = wr_pm0 ? (reg_wdata_i & `APDC_PM0_MASK) : pm0_q; // [R11]
    assign pm2_d = wr_pm2 ? (reg_wdata_i & `APDC_PM2_MASK) : pm2_q; // [R11]

    // Only power-up clears them; warm reset leaves them alone
    always_ff @(posedge sys_clk_i) begin
        if (por_i) begin
            pm0_q <= `APDC_REG_RST; // [R16]
            pm2_q <= `APDC_REG_RST; // [R16]
        end else begin
            pm0_q <= pm0_d;
            pm2_q <= pm2_d;
        end
    end

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    wire apd_en = pm0_q[`APDC_PM0_APD_EN]; // [R2]
    wire turbo_off = pm0_q[`APDC_PM0_TURBO_OFF]; // [R8]
    wire arr_clk_off = pm0_q[`APDC_PM0_ARR_CLK_OFF]; // [R9]
    wire mcell_clk_off = pm0_q[`APDC_PM0_MCELL_CLK_OFF]; // [R10]
    wire wr_off = pm2_q[`APDC_PM2_WR_OFF]; // [R14]
    wire rd_off = pm2_q[`APDC_PM2_RD_OFF]; // [R14]
    wire program_store_enable_off = pm2_q[`APDC_PM2_PROGRAM_STORE_ENABLE_OFF]; // [R14]
    wire ale_off = pm2_q[`APDC_PM2_ALE_OFF]; // [R14]

    // ------------------------------------------------------------------
    // Idle detection
    // ------------------------------------------------------------------
    apdc_state_e state_q;
    apdc_state_e state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    // Counter sees the raw input clock, not the PLD-gated copy
    wire period_tick = inclk_s & ~clk_prev_q; // [R6]
    wire ale_edge = ale_s ^ ale_prev_q; // [R15]
    wire cs_sel = ~cs_n_s;

    // Any of these forces normal operation and restarts counting
    wire wake = ale_edge | cs_sel | srst_i; // [R3] [R4] [R17]

    wire [CNT_W-1:0] cnt_inc = cnt_q + CNT_W'(1);
    wire idle_done = (cnt_inc == CNT_W'(`APDC_IDLE_PERIODS)); // [R1]

    // Next state and counter
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            APDC_OFF: begin
                cnt_d = CNT_W'(`APDC_CNT_RST);
                if (apd_en) begin
                    state_d = APDC_WATCH; // [R2]
                end
            end
            APDC_WATCH: begin
                if (!apd_en) begin
                    state_d = APDC_OFF; // [R15]
                    cnt_d = CNT_W'(`APDC_CNT_RST);
                end else if (wake) begin
                    cnt_d = CNT_W'(`APDC_CNT_RST); // [R17]
                end else if (period_tick) begin
                    cnt_d = cnt_inc; // [R1]
                    if (idle_done) begin
                        state_d = APDC_DOWN; // [R1]
                    end
                end
            end
            APDC_DOWN: begin
                if (!apd_en) begin
                    state_d = APDC_OFF;
                    cnt_d = CNT_W'(`APDC_CNT_RST);
                end else if (wake) begin
                    state_d = APDC_WATCH; // [R3] [R4]
                    cnt_d = CNT_W'(`APDC_CNT_RST); // [R17]
                end
            end
            default: begin
                state_d = APDC_OFF;
                cnt_d = CNT_W'(`APDC_CNT_RST);
            end
        endcase
    end

    // Warm reset only restarts the watch through wake; the enable bit survives it
    always_ff @(posedge sys_clk_i) begin
        if (por_i) begin
            state_q <= APDC_OFF;
            cnt_q <= CNT_W'(`APDC_CNT_RST);
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    wire pdn_d = (state_d == APDC_DOWN);
    wire counting = (state_q == APDC_WATCH);

    // ------------------------------------------------------------------
    // Output decode
    // ------------------------------------------------------------------
    apdc_pld_ctrl_s pld_ctrl_d;
    apdc_pin_ctrl_s pin_ctrl_d;

    // Disconnected strobes sit at their inactive level
    assign pld_ctrl_d.wr_n = wr_n_s | wr_off; // [R13]
    assign pld_ctrl_d.rd_n = rd_n_s | rd_off; // [R13]
    assign pld_ctrl_d.program_store_enable_n = program_store_enable_n_s | program_store_enable_off; // [R13]
    assign pld_ctrl_d.ale = ale_s & ~ale_off; // [R13]

    // Pin behaviour follows the flag, nothing else
    assign pin_ctrl_d.hold_mcu_io = pdn_d; // [R7]
    assign pin_ctrl_d.hold_pld_out = pdn_d; // [R7]
    assign pin_ctrl_d.addr_out_invalid = pdn_d; // [R7]
    assign pin_ctrl_d.periph_tristate = pdn_d; // [R7]

    // Chip-select gates memories only; PLD and I/O stay live
    wire mem_en_d = cs_sel & ~pdn_d; // [R5] [R12]

    // Clock copies into the PLD, gated per field
    wire arr_clk_d = inclk_s & ~arr_clk_off; // [R9]
    wire mcell_clk_d = inclk_s & ~mcell_clk_off; // [R10]

    // ------------------------------------------------------------------
    // Status and read data
    // ------------------------------------------------------------------
    logic pdn_q;
    apdc_reg_t stat;
    apdc_reg_t rdata_d;

    always_comb begin
        stat = `APDC_REG_RST;
        stat[`APDC_STAT_PDN] = pdn_q;
        stat[`APDC_STAT_CNTG] = counting;
        stat[`APDC_STAT_CNT_LSB +: CNT_W] = cnt_q;
    end

    // Unmapped addresses read zero
    assign rdata_d = !reg_rd_i ? `APDC_REG_RST :
                     sel_pm0 ? pm0_q :
                     sel_pm2 ? pm2_q :
                     sel_stat ? stat :
                     `APDC_REG_RST;

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    // Registered so every pin-facing output is glitch free
    always_ff @(posedge sys_clk_i) begin
        if (por_i) begin
            pdn_q <= 1'b0;
            reg_rdata_o <= `APDC_REG_RST;
            mem_enable_o <= 1'b0;
            pld_turbo_off_o <= 1'b0;
            pld_array_clk_o <= 1'b0;
            pld_mcell_clk_o <= 1'b0;
            pld_ctrl_o <= '0;
            pin_ctrl_o <= '0;
        end else begin
            pdn_q <= pdn_d; // [R1]
            reg_rdata_o <= rdata_d;
            mem_enable_o <= mem_en_d; // [R5] [R12]
            pld_turbo_off_o <= turbo_off; // [R8]
            pld_array_clk_o <= arr_clk_d; // [R9]
            pld_mcell_clk_o <= mcell_clk_d; // [R10]
            pld_ctrl_o <= pld_ctrl_d; // [R13]
            pin_ctrl_o <= pin_ctrl_d; // [R7]
        end
    end

    // Bus block is the flag itself
    assign power_down_flag_o = pdn_q;
    assign mcu_bus_block_o = pdn_q; // [R5]

endmodule : apdc_top

// *** apdc_top_tb.sv ***
/*
 * Self-checking bench for apdc_top: registers, idle entry, wake paths.
 * Assumes the MCU pin model drives every pin input of the device.
 */
`timescale 1ns/100ps
`include "apdc_defines.svh"
module apdc_top_tb import apdc_pkg::*;;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
        logic turbo;
    } apdc_tb_row_s;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic por_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic ale_run = 1'b1;
    logic cs_n = 1'b1;
    logic [7:0] reg_rdata_o;
    logic [7:0] rv;
    logic ale, pin_clk, cs_n_pin, wr_n, rd_n, program_store_enable_n;
    logic power_down_flag_o, mcu_bus_block_o, mem_enable_o;
    logic pld_turbo_off_o, pld_array_clk_o, pld_mcell_clk_o;
    apdc_pld_ctrl_s pld_ctrl_o;
    apdc_pin_ctrl_s pin_ctrl_o;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    // Software keeps unused bits at zero in every write except the FF to unmapped 8'h10
    apdc_tb_row_s rows [6] = '{
        '{`APDC_PM0_OFS, 8'h3A, 8'h3A, 1'b1}, '{`APDC_PM2_OFS, 8'h3C, 8'h3C, 1'b1},
        '{`APDC_PM0_OFS, 8'h08, 8'h08, 1'b1}, '{`APDC_PM0_OFS, 8'h32, 8'h32, 1'b0},
        '{`APDC_PM2_OFS, 8'h14, 8'h14, 1'b0}, '{8'h10, 8'hFF, 8'h00, 1'b0}};

    apdc_mcu_model mcu (
        .clk_i(sys_clk_i), .ale_run_i(ale_run), .cs_n_i(cs_n), .ale_o(ale),
        .pin_clk_o(pin_clk), .cs_n_o(cs_n_pin), .wr_n_o(wr_n), .rd_n_o(rd_n),
        .program_store_enable_n_o(program_store_enable_n)
    );
    apdc_top dut (
        .sys_clk_i, .srst_i, .por_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .ale_pin_i(ale), .pld_input_clock_i(pin_clk),
        .chip_select_n_i(cs_n_pin), .mcu_wr_n_i(wr_n), .mcu_rd_n_i(rd_n),
        .program_store_enable_n_i(program_store_enable_n), .power_down_flag_o, .mcu_bus_block_o,
        .mem_enable_o, .pld_turbo_off_o, .pld_array_clk_o, .pld_mcell_clk_o,
        .pld_ctrl_o, .pin_ctrl_o
    );

    // ------------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------------
    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    // Whole run is about a thousand cycles; this ceiling means a hang
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        d = reg_rdata_o;
    endtask : rd
    task automatic wait_flag(input logic v, input int lim);
        n = 0;
        while (power_down_flag_o !== v && n < lim) begin
            @(negedge sys_clk_i);
            n++;
        end
        check("power-down flag", {7'h00, v}, {7'h00, power_down_flag_o});
    endtask : wait_flag
    task automatic stop_test();
        $display("Checks %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk_i);
        por_i <= 1'b0;
        srst_i <= 1'b0;
        rd(`APDC_PM0_OFS, rv);
        check("ctrl0 reset", 8'h00, rv);
        rd(`APDC_PM2_OFS, rv);
        check("ctrl2 reset", 8'h00, rv);
        check("mem enable cs high", 8'h00, {7'h00, mem_enable_o});
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rv);
            check("readback", rows[i].exp, rv);
            check("turbo", {7'h00, rows[i].turbo}, {7'h00, pld_turbo_off_o});
        end
        // All strobes cut off and pin clock gated while the MCU is busy
        wr(`APDC_PM2_OFS, 8'h3C);
        // Outputs are registered from the control fields: one more edge
        @(posedge sys_clk_i);
        repeat (16) begin
            @(negedge sys_clk_i);
            rv = {2'b00, pld_ctrl_o, pld_array_clk_o, pld_mcell_clk_o};
            check("pld gating", 8'h38, rv);
        end
        ale_run <= 1'b0;
        repeat (100) @(posedge sys_clk_i);
        check("early power-down", 8'h00, {7'h00, power_down_flag_o});
        wait_flag(1'b1, 80);
        check("blocking", 8'h2F, {2'b00, mcu_bus_block_o, mem_enable_o, pin_ctrl_o});
        rd(`APDC_STAT_OFS, rv);
        check("status", {`APDC_IDLE_PERIODS, 4'h1}, rv);
        ale_run <= 1'b1;
        wait_flag(1'b0, 10);
        ale_run <= 1'b0;
        wait_flag(1'b1, 140);
        cs_n <= 1'b0;
        wait_flag(1'b0, 10);
        repeat (200) @(posedge sys_clk_i);
        check("no entry cs low", 8'h01, {6'h00, power_down_flag_o, mem_enable_o});
        cs_n <= 1'b1;
        wait_flag(1'b1, 140);
        @(posedge sys_clk_i);
        srst_i <= 1'b1;
        @(posedge sys_clk_i);
        srst_i <= 1'b0;
        wait_flag(1'b0, 4);
        rd(`APDC_PM0_OFS, rv);
        check("ctrl0 kept", 8'h32, rv);
        wait_flag(1'b1, 140);
        wr(`APDC_PM0_OFS, 8'h30);
        repeat (200) @(posedge sys_clk_i);
        check("disabled", 8'h00, {7'h00, power_down_flag_o});
        stop_test();
    end
endmodule : apdc_top_tb
